//--- inc/awu_pkg.sv
// package: register map, fields, reset values and timing constants
package awu_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] PRESCALER_ADDR = 8'h49;
	localparam logic [7:0] CTRL_STATUS_ADDR = 8'h4A;
	localparam logic [7:0] PRESCALER_RESET = 8'hFF;
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
	localparam int ENABLE_BIT = 0;
	localparam int MEASURE_BIT = 1;
	localparam int FLAG_BIT = 2;
	// ==========================================
	// timing
	localparam int FIXED_DIV = 64;
	localparam int STAB_SHORT = 256;
	localparam int STAB_LONG = 4096;
	localparam int CLK_MHZ = 25;
	localparam real PLL_STARTUP_US = 4.0;
	localparam int PLL_STARTUP_CYC =
		(int'($ceil(PLL_STARTUP_US * CLK_MHZ)) < 1) ? 1 :
		int'($ceil(PLL_STARTUP_US * CLK_MHZ));
	localparam int RC_STARTUP_RC_CYC = 2;

	typedef enum {
		ST_RUN,
		ST_RC_START,
		ST_TIMED,
		ST_PLAIN_HALT,
		ST_STAB,
		ST_PLL
	} awu_state_t;

	// bus request from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} awu_bus_t;
endpackage

//--- verilog/awu_top.sv
// auto wake-up from halt: registers, rc divider chain and halt sequencer
// Notes on behaviour
// [R01] halt with wake-up enabled enters timed wake-up halt, not plain halt
// [R02] rc oscillator runs and clocks the divider chain once timed halt begins
// [R03] delay is 64 times prescaler rc periods plus rc start-up time
// [R04] delay end sets wake-up flag and raises wake-up interrupt
// [R05] main oscillator restarts at once; 256 or 4096 cycles stabilisation
// [R06] reading control/status clears flag and interrupt; writes leave flag
// [R07] measure bit in run mode enables rc and routes it to timer capture
// [R08] software sets and clears wake-up enable to choose timed wake-up
// [R09] any halt-exit interrupt or reset also ends timed halt
// [R10] entering timed halt forces global interrupt mask to zero
// [R11] in timed halt main oscillator off, peripherals unclocked
// [R12] watchdog-halt option may give watchdog reset instead of halt
// [R13] prescaler value is dividing factor 1..255; zero forbidden
// [R14] writing zero to prescaler keeps the previous value
// [R15] control/status bits 7 to 3 read as zero
// [R16] reset: prescaler FFh, control/status 00h
// [R17] with pll enabled, extra pll start-up delay after stabilisation
// [R18] a flag set in the same cycle as a clearing read is kept
//
// Chosen here: the plain strobed port.
module awu_top #(
	parameter int STAB_SHORT_CYC = awu_pkg::STAB_SHORT,
	parameter int STAB_LONG_CYC = awu_pkg::STAB_LONG,
	parameter int PLL_CYC = awu_pkg::PLL_STARTUP_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// cpu and power management
	input wire logic i_halt_exec,
	input wire logic i_wdg_enabled,
	input wire logic i_watchdog_halt_option,
	input wire logic i_long_stab,
	input wire logic i_pll_enable,
	input wire logic i_halt_exit_irq,
	input wire logic i_rc_tick,
	output logic o_main_osc_on,
	output logic o_periph_clk_en,
	output logic o_cpu_run,
	output logic o_clear_int_mask,
	output logic o_wdg_reset,
	output logic o_wakeup_irq,
	// rc oscillator and timer capture
	output logic o_rc_osc_enable,
	output logic o_capture_select,
	output logic o_timed_halt_wakeup_mode
);
	// ==========================================
	// parameter checks: delays load straight into a 16-bit counter
	initial begin
		if (STAB_SHORT_CYC < 1)
			$error("awu_top: short stabilisation below one cycle");
		if (STAB_LONG_CYC < STAB_SHORT_CYC)
			$error("awu_top: long stabilisation shorter than short");
		if (STAB_LONG_CYC > 65535)
			$error("awu_top: long stabilisation exceeds counter");
		if (PLL_CYC < 1)
			$error("awu_top: pll start-up below one cycle");
		if (PLL_CYC > 65535)
			$error("awu_top: pll start-up exceeds counter");
		if (awu_pkg::FIXED_DIV != 64)
			$error("awu_top: fixed divider counter is six bits");
		if (awu_pkg::RC_STARTUP_RC_CYC < 1)
			$error("awu_top: rc start-up below one tick");
	end

	// ==========================================
	// registers
	awu_pkg::awu_bus_t bus;
	logic [7:0] prescaler_q, prescaler_d;
	logic enable_q;
	logic enable_d;
	logic measure_q;
	logic measure_d;
	logic flag_q;
	logic flag_d;
	logic [7:0] rdata_d;
	logic set_flag;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// control/status image: reserved bits always read as zero
	function automatic logic [7:0] csr_image(input logic en,
		input logic meas, input logic flg);
		logic [7:0] img;
		img = 8'h00;
		img[awu_pkg::ENABLE_BIT] = en;
		img[awu_pkg::MEASURE_BIT] = meas;
		img[awu_pkg::FLAG_BIT] = flg;
		return img;
	endfunction

	always_comb begin
		prescaler_d = prescaler_q;
		enable_d = enable_q;
		measure_d = measure_q;
		flag_d = flag_q;
		rdata_d = 8'h00;
		if (bus.wr && hit(bus.addr, awu_pkg::PRESCALER_ADDR) &&
			bus.wdata != 8'h00)
			prescaler_d = bus.wdata; // [R13] [R14]
		if (bus.wr && hit(bus.addr, awu_pkg::CTRL_STATUS_ADDR)) begin
			enable_d = bus.wdata[awu_pkg::ENABLE_BIT]; // [R08]
			measure_d = bus.wdata[awu_pkg::MEASURE_BIT];
		end
		if (bus.rd && hit(bus.addr, awu_pkg::PRESCALER_ADDR))
			rdata_d = prescaler_q;
		if (bus.rd && hit(bus.addr, awu_pkg::CTRL_STATUS_ADDR)) begin
			rdata_d = csr_image(enable_q, measure_q, flag_q); // [R15]
			flag_d = 1'b0; // [R06]
		end
		if (set_flag)
			flag_d = 1'b1; // [R04] [R18]
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prescaler_q <= awu_pkg::PRESCALER_RESET; // [R16]
			enable_q <= awu_pkg::CTRL_STATUS_RESET[awu_pkg::ENABLE_BIT];
			measure_q <= awu_pkg::CTRL_STATUS_RESET[awu_pkg::MEASURE_BIT];
			flag_q <= awu_pkg::CTRL_STATUS_RESET[awu_pkg::FLAG_BIT];
			o_rdata <= 8'h00;
		end else begin
			prescaler_q <= prescaler_d;
			enable_q <= enable_d;
			measure_q <= measure_d;
			flag_q <= flag_d;
			o_rdata <= rdata_d;
		end
	end

	// ==========================================
	// halt sequencer and rc divider chain
	awu_pkg::awu_state_t state_q, state_d;
	logic [5:0] div_q, div_d;
	logic [7:0] pre_q, pre_d;
	logic [15:0] cnt_q, cnt_d;
	logic set_flag_d;
	logic wdg_rst_d;
	logic main_osc_on_d;
	logic periph_clk_en_d;
	logic cpu_run_d;
	logic clear_int_mask_d;
	logic wakeup_irq_d;
	logic rc_osc_enable_d;
	logic capture_select_d;
	logic timed_mode_d;

	// rc start-up and delay count are both timed halt
	function automatic logic timed_state(input awu_pkg::awu_state_t s);
		return s == awu_pkg::ST_RC_START || s == awu_pkg::ST_TIMED;
	endfunction

	always_comb begin
		state_d = state_q;
		div_d = div_q;
		pre_d = pre_q;
		cnt_d = cnt_q;
		set_flag_d = 1'b0;
		wdg_rst_d = 1'b0;
		unique case (state_q)
			awu_pkg::ST_RUN: begin
				if (i_halt_exec) begin
					if (i_wdg_enabled && !i_watchdog_halt_option)
						wdg_rst_d = 1'b1; // [R12]
					else if (enable_q) begin
						state_d = awu_pkg::ST_RC_START; // [R01]
						cnt_d = 16'(awu_pkg::RC_STARTUP_RC_CYC);
					end else
						state_d = awu_pkg::ST_PLAIN_HALT;
				end
			end
			awu_pkg::ST_RC_START: begin
				if (i_halt_exit_irq)
					state_d = awu_pkg::ST_STAB; // [R09]
				else if (i_rc_tick) begin
					if (cnt_q == 16'h0001) begin
						state_d = awu_pkg::ST_TIMED; // [R02]
						div_d = 6'(awu_pkg::FIXED_DIV - 1);
						pre_d = prescaler_q;
					end else
						cnt_d = cnt_q - 16'h0001;
				end
			end
			awu_pkg::ST_TIMED: begin
				if (i_halt_exit_irq)
					state_d = awu_pkg::ST_STAB; // [R09]
				else if (i_rc_tick) begin
					if (div_q != 6'h00)
						div_d = div_q - 6'h01; // [R03]
					else begin
						div_d = 6'(awu_pkg::FIXED_DIV - 1);
						if (pre_q == 8'h01) begin
							state_d = awu_pkg::ST_STAB;
							set_flag_d = 1'b1; // [R04]
						end else
							pre_d = pre_q - 8'h01; // [R03]
					end
				end
			end
			awu_pkg::ST_PLAIN_HALT: begin
				if (i_halt_exit_irq)
					state_d = awu_pkg::ST_STAB;
			end
			awu_pkg::ST_STAB: begin
				if (cnt_q == 16'h0001) begin
					if (i_pll_enable) begin
						state_d = awu_pkg::ST_PLL; // [R17]
						cnt_d = 16'(PLL_CYC);
					end else
						state_d = awu_pkg::ST_RUN;
				end else
					cnt_d = cnt_q - 16'h0001; // [R05]
			end
			awu_pkg::ST_PLL: begin
				if (cnt_q == 16'h0001)
					state_d = awu_pkg::ST_RUN;
				else
					cnt_d = cnt_q - 16'h0001;
			end
		endcase
		if (state_d == awu_pkg::ST_STAB && state_q != awu_pkg::ST_STAB)
			cnt_d = i_long_stab ? 16'(STAB_LONG_CYC) : 16'(STAB_SHORT_CYC);
	end

	assign set_flag = set_flag_d;

	// ==========================================
	// output next values
	always_comb begin
		// [R05] [R11] oscillator off only while halted; peripherals stay off until run resumes
		main_osc_on_d = !(timed_state(state_d) ||
			state_d == awu_pkg::ST_PLAIN_HALT);
		periph_clk_en_d = state_d == awu_pkg::ST_RUN; // [R11]
		cpu_run_d = state_d == awu_pkg::ST_RUN; // [R05] [R17]
		clear_int_mask_d = i_halt_exec &&
			state_q == awu_pkg::ST_RUN && !wdg_rst_d; // [R10]
		wakeup_irq_d = flag_d; // [R04] [R06]
		capture_select_d = measure_d &&
			state_d == awu_pkg::ST_RUN; // [R07]
		rc_osc_enable_d = timed_state(state_d) ||
			capture_select_d; // [R02] [R07]
		timed_mode_d = timed_state(state_d); // [R01]
	end

	// ==========================================
	// state and output registers

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= awu_pkg::ST_RUN;
			div_q <= 6'h00;
			pre_q <= 8'h00;
			cnt_q <= 16'h0000;
			o_main_osc_on <= 1'b1;
			o_periph_clk_en <= 1'b1;
			o_cpu_run <= 1'b1;
			o_clear_int_mask <= 1'b0;
			o_wdg_reset <= 1'b0;
			o_wakeup_irq <= 1'b0;
			o_rc_osc_enable <= 1'b0;
			o_capture_select <= 1'b0;
			o_timed_halt_wakeup_mode <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			o_main_osc_on <= main_osc_on_d;
			o_periph_clk_en <= periph_clk_en_d;
			o_cpu_run <= cpu_run_d;
			o_clear_int_mask <= clear_int_mask_d;
			o_wdg_reset <= wdg_rst_d; // [R12]
			o_wakeup_irq <= wakeup_irq_d;
			o_rc_osc_enable <= rc_osc_enable_d;
			o_capture_select <= capture_select_d;
			o_timed_halt_wakeup_mode <= timed_mode_d;
		end
	end
endmodule

//--- sim/awu_cpu_model.sv
// partner: rc oscillator of the halt logic, ticking while enabled
module awu_cpu_model (
	// clock
	input wire logic i_clk,
	// rc request and tick
	input wire logic i_rc_en,
	output logic o_rc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	// rc clock stands still unless the block enables it
	initial o_rc_tick = 1'b0;
	always @(posedge i_clk) o_rc_tick <= i_rc_en && !o_rc_tick;
endmodule

//--- sim/awu_top_monitor.sv
// checker: port relations of the auto wake-up block
module awu_mon (
	// clock and inputs
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic i_rd,
	input wire logic i_halt_exec,
	input wire logic i_wdg_enabled,
	input wire logic i_watchdog_halt_option,
	input wire logic i_halt_exit_irq,
	// outputs
	input wire logic [7:0] o_rdata,
	input wire logic o_main_osc_on,
	input wire logic o_periph_clk_en,
	input wire logic o_cpu_run,
	input wire logic o_clear_int_mask,
	input wire logic o_wdg_reset,
	input wire logic o_wakeup_irq,
	input wire logic o_rc_osc_enable,
	input wire logic o_capture_select,
	input wire logic o_timed_halt_wakeup_mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_RSVD: assert property (i_rd && i_addr == 8'h4A |=>
		o_rdata[7:3] == 5'h00) else $error("reserved bits set");
	AST_RDCLR: assert property (i_rd && i_addr == 8'h4A &&
		!o_timed_halt_wakeup_mode |=> !o_wakeup_irq) else $error("irq kept");
	AST_ENTER: assert property ($rose(o_timed_halt_wakeup_mode) |->
		o_clear_int_mask && $past(i_halt_exec)) else $error("bad entry");
	AST_OFF: assert property (o_timed_halt_wakeup_mode |->
		!o_main_osc_on && !o_periph_clk_en && o_rc_osc_enable) else $error("on");
	AST_WDG: assert property (i_halt_exec && o_cpu_run &&
		i_wdg_enabled && !i_watchdog_halt_option |=> o_wdg_reset)
		else $error("no wdg reset");
	AST_STAB: assert property ($rose(o_main_osc_on) |->
		!o_cpu_run [*4] ##[1:40] o_cpu_run) else $error("bad stabilisation");
	AST_EXIT: assert property (o_timed_halt_wakeup_mode &&
		i_halt_exit_irq |-> ##[1:3] !o_timed_halt_wakeup_mode)
		else $error("no exit");
	AST_MEAS: assert property (o_capture_select |-> o_cpu_run &&
		o_rc_osc_enable) else $error("bad capture route");
endmodule

//--- sim/tb.sv
// testbench: registers, timed halt, halt exits, measure mode
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_halt_exec = 0;
	logic i_wdg_enabled = 0, i_watchdog_halt_option = 0, i_long_stab = 0;
	logic i_pll_enable = 0, i_halt_exit_irq = 0, i_rc_tick;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic o_main_osc_on, o_periph_clk_en, o_cpu_run, o_clear_int_mask;
	logic o_wdg_reset, o_wakeup_irq, o_rc_osc_enable, o_capture_select;
	logic o_timed_halt_wakeup_mode;
	int num_errors = 0, checks = 0, ticks = 0, k, n;
	awu_top #(.STAB_SHORT_CYC(4), .STAB_LONG_CYC(16), .PLL_CYC(2)) dut_u (.*);
	awu_cpu_model cpu_u (.i_clk(i_clk), .i_rc_en(o_rc_osc_enable),
		.o_rc_tick(i_rc_tick));
	initial forever #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (i_rc_tick) ticks++;
	// ====
	// tasks
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, s);
		checks++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", {8'h00, e}, {8'h00, o_rdata});
	endtask
	task halt;
		@(posedge i_clk);
		i_halt_exec <= 1'b1;
		ticks = 0;
		@(posedge i_clk);
		i_halt_exec <= 1'b0;
	endtask
	// bounded wait: 0 irq, 1 cpu running, 2 watchdog reset
	task wt(input int s, input int lim);
		n = 0;
		#1;
		while (!(s == 0 ? o_wakeup_irq : s == 1 ? o_cpu_run : o_wdg_reset)) begin
			@(posedge i_clk);
			#1;
			n++;
			if (n > lim) begin
				num_errors++;
				give_verdict();
			end
		end
	endtask
	// ====
	// sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(8'h49, 8'hFF);
		rd(8'h4A, 8'h00);
		rd(8'h50, 8'h00);
		wr(8'h49, 8'h00);
		rd(8'h49, 8'hFF);
		wr(8'h4A, 8'hFF);
		rd(8'h4A, 8'h03);
		chk("capture", 16'h0001, {15'h0000, o_capture_select});
		chk("rc_en", 16'h0001, {15'h0000, o_rc_osc_enable});
		wr(8'h4A, 8'h01);
		$display("test registers done");
		for (k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_long_stab <= k[0];
			i_pll_enable <= k[0];
			wr(8'h49, k ? 8'hFF : 8'h01);
			halt();
			// mode, osc, mask clear, rc enable, peripherals
			#1 chk("halt_outs", 16'h0016, {11'h000,
				o_timed_halt_wakeup_mode, o_main_osc_on,
				o_clear_int_mask, o_rc_osc_enable, o_periph_clk_en});
			wt(0, 40000);
			chk("ticks", k ? 16'h3FC2 : 16'h0042, 16'(ticks));
			chk("osc", 16'h0002, {14'h0000, o_main_osc_on, o_cpu_run});
			wt(1, 100);
			chk("stab", k ? 16'h0012 : 16'h0004, 16'(n));
			rd(8'h4A, 8'h05);
			rd(8'h4A, 8'h01);
			chk("irq", 16'h0000, {15'h0000, o_wakeup_irq});
		end
		$display("test timed halt done");
		halt();
		repeat (10) @(posedge i_clk);
		i_halt_exit_irq <= 1'b1;
		wt(1, 100);
		@(posedge i_clk);
		i_halt_exit_irq <= 1'b0;
		rd(8'h4A, 8'h01);
		@(posedge i_clk);
		i_wdg_enabled <= 1'b1;
		halt();
		wt(2, 10);
		chk("wdg", 16'h0001, {15'h0000, o_wdg_reset});
		$display("test halt exits done");
		give_verdict();
	end
endmodule
bind awu_top awu_mon mon_u (.*);
